/* logic/adf_top.sv */
// Purpose: Audio decimation filters: stereo, mono and decimation-by-six
// Assumes: clk is the crystal clock; all inputs synchronous to it
// Notes:   APB slave, zero wait states after setup, registered answers
`timescale 1ns/1ps
`include "adf_defines.svh"
module adf_top
    import adf_pkg::*;
(
    input  wire logic        clk,               // Crystal clock, 40 MHz
    input  wire logic        rst_n,             // Async reset, active low
    input  wire logic [7:0]  paddr,             // APB address
    input  wire logic        psel,              // APB select
    input  wire logic        penable,           // APB enable
    input  wire logic        pwrite,            // APB direction
    input  wire logic [31:0] pwdata,            // APB write data
    output logic      [31:0] prdata,            // APB read data
    output logic             pready,            // APB ready
    output logic             pslverr,           // APB error
    input  wire logic        mod_bit_left,      // Internal converter left
    input  wire logic        mod_bit_right,     // Internal converter right
    input  wire logic        mod_bit_mono,      // Internal converter mono
    input  wire logic        ext_sample_in_left,  // External left pin
    input  wire logic        ext_sample_in_right, // External right pin
    input  wire logic        ext_sample_in_mono,  // External mono pin
    input  wire adf_pair_s   fm_smp,            // FM demodulator samples
    output logic             irq_stereo,        // Stereo sample pulse
    output logic             irq_mono,          // Mono sample pulse
    output logic             irq_dec6,          // Decimation-by-six pulse
    output logic             fm_demod_rst,      // FM demodulator reset
    output logic             xclk_div2,         // Crystal / 2 out
    output logic             xclk_div4          // Crystal / 4 out
);
    // ************************************************************
    // Configuration registers and APB slave
    // ************************************************************
    adf_ctrl_s   ctrl_q, ctrl_d;
    adf_cfg_s    cfg_q, cfg_d;
    logic [31:0] prdata_q, prdata_d, rd_mux;
    logic        pready_q, pready_d, pslverr_q, pslverr_d, rd_hit;
    logic        demod_rst_q, demod_rst_d;
    logic        wr_acc;
    logic [17:0] left_q, right_q, mono_q, d6l_q, d6r_q;

    function automatic logic [31:0] hi_w(input logic [17:0] v);
        hi_w = {16'h0000, v[17:2]};
    endfunction
    function automatic logic [31:0] lo_w(input logic [17:0] v);
        lo_w = {16'h0000, v[1:0], 14'h0000};
    endfunction

    always_comb begin
        rd_hit = 1'b1;
        case (paddr)
            `ADF_OFF_CTRL: begin
                rd_mux = 32'h0000_0000;
                rd_mux[`ADF_CTRL_EXT_R_BIT] = ctrl_q.ext_r;
                rd_mux[`ADF_CTRL_EXT_L_BIT] = ctrl_q.ext_l;
                rd_mux[`ADF_CTRL_EXT_M_BIT] = ctrl_q.ext_m;
                rd_mux[`ADF_CTRL_ENA_BIT]   = ctrl_q.glb_en;
            end
            `ADF_OFF_CFG:       rd_mux = {22'h000000, cfg_q};
            `ADF_OFF_LEFT:      rd_mux = hi_w(left_q);
            `ADF_OFF_LEFT_LSB:  rd_mux = lo_w(left_q);
            `ADF_OFF_RIGHT:     rd_mux = hi_w(right_q);
            `ADF_OFF_RIGHT_LSB: rd_mux = lo_w(right_q);
            `ADF_OFF_MONO:      rd_mux = hi_w(mono_q);
            `ADF_OFF_MONO_LSB:  rd_mux = lo_w(mono_q);
            `ADF_OFF_D6L:       rd_mux = hi_w(d6l_q);
            `ADF_OFF_D6L_LSB:   rd_mux = lo_w(d6l_q);
            `ADF_OFF_D6R:       rd_mux = hi_w(d6r_q);
            `ADF_OFF_D6R_LSB:   rd_mux = lo_w(d6r_q);
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
        wr_acc    = psel && penable && pready_q && pwrite;
        pready_d  = psel && !penable;
        prdata_d  = pready_d ? (pwrite ? 32'h0000_0000 : rd_mux) : prdata_q;
        pslverr_d = pready_d ? !rd_hit : pslverr_q;
        ctrl_d    = ctrl_q;
        cfg_d     = cfg_q;
        if (wr_acc && paddr == `ADF_OFF_CTRL) begin
            ctrl_d.ext_r  = pwdata[`ADF_CTRL_EXT_R_BIT];
            ctrl_d.ext_l  = pwdata[`ADF_CTRL_EXT_L_BIT];
            ctrl_d.ext_m  = pwdata[`ADF_CTRL_EXT_M_BIT];
            ctrl_d.glb_en = pwdata[`ADF_CTRL_ENA_BIT];
        end
        if (wr_acc && paddr == `ADF_OFF_CFG)
            cfg_d = pwdata[`ADF_CFG_MSB:0];
        demod_rst_d = !ctrl_d.glb_en;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q      <= `ADF_CTRL_RST;
            cfg_q       <= `ADF_CFG_RST;
            prdata_q    <= 32'h0000_0000;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            demod_rst_q <= 1'b1;
        end else begin
            ctrl_q      <= ctrl_d;
            cfg_q       <= cfg_d;
            prdata_q    <= prdata_d;
            pready_q    <= pready_d;
            pslverr_q   <= pslverr_d;
            demod_rst_q <= demod_rst_d;
        end
    end

    // ************************************************************
    // Input routing and audio filters
    // ************************************************************
    logic en_div2, b_left, b_right, b_mono, src_right, src_mono;
    logic st_clr, mono_clr, d6_clr;
    logic [17:0] st_l_data, st_r_data, mono_data;
    logic        st_valid, st_r_valid, mono_valid;

    adf_clkdiv u_div (
        .clk     (clk),
        .rst_n   (rst_n),
        .en_div2 (en_div2),
        .div2_q  (xclk_div2),
        .div4_q  (xclk_div4)
    );

    always_comb begin
        b_left    = ctrl_q.ext_l ? ext_sample_in_left : mod_bit_left;
        src_right = ctrl_q.ext_r ? ext_sample_in_right : mod_bit_right;
        src_mono  = ctrl_q.ext_m ? ext_sample_in_mono : mod_bit_mono;
        b_right   = cfg_q.swap ? src_mono : src_right;
        b_mono    = cfg_q.swap ? src_right : src_mono;
        st_clr    = !(ctrl_q.glb_en && cfg_q.st_en);
        mono_clr  = !(ctrl_q.glb_en && cfg_q.mono_en);
        d6_clr    = !(ctrl_q.glb_en && cfg_q.d6_en);
    end

    adf_decim u_left (
        .clk     (clk),
        .rst_n   (rst_n),
        .clr     (st_clr),
        .smp_en  (en_div2),
        .bit_in  (b_left),
        .rate    (cfg_q.st_rate),
        .data_q  (st_l_data),
        .valid_q (st_valid)
    );

    adf_decim u_right (
        .clk     (clk),
        .rst_n   (rst_n),
        .clr     (st_clr),
        .smp_en  (en_div2),
        .bit_in  (b_right),
        .rate    (cfg_q.st_rate),
        .data_q  (st_r_data),
        .valid_q (st_r_valid)
    );

    adf_decim u_mono (
        .clk     (clk),
        .rst_n   (rst_n),
        .clr     (mono_clr),
        .smp_en  (en_div2),
        .bit_in  (b_mono),
        .rate    (cfg_q.mono_rate),
        .data_q  (mono_data),
        .valid_q (mono_valid)
    );

    // ************************************************************
    // Decimation-by-six filter
    // ************************************************************
    adf_d6src_e         d6_src;
    adf_pair_s          d6_in;
    logic [2:0]         d6_cnt_q, d6_cnt_d;
    logic signed [20:0] d6_al_q, d6_al_d, d6_ar_q, d6_ar_d, sum_l, sum_r;
    logic               d6_done;

    always_comb begin
        case (cfg_q.d6_sel)
            2'h0:    d6_src = ADF_D6_FM;
            2'h1:    d6_src = ADF_D6_STEREO;
            default: d6_src = ADF_D6_MONO;
        endcase
        case (d6_src)
            ADF_D6_FM:     d6_in = fm_smp;
            ADF_D6_STEREO: d6_in = {st_valid, st_l_data, st_r_data};
            ADF_D6_MONO:   d6_in = {mono_valid, mono_data, mono_data};
            default:       d6_in = '0;
        endcase
        sum_l    = d6_al_q + 21'(signed'(d6_in.left));
        sum_r    = d6_ar_q + 21'(signed'(d6_in.right));
        d6_done  = !d6_clr && d6_in.valid && d6_cnt_q == `ADF_D6_LAST;
        d6_cnt_d = d6_cnt_q;
        d6_al_d  = d6_al_q;
        d6_ar_d  = d6_ar_q;
        if (d6_clr) begin
            d6_cnt_d = 3'h0;
            d6_al_d  = 21'sd0;
            d6_ar_d  = 21'sd0;
        end else if (d6_done) begin
            d6_cnt_d = 3'h0;
            d6_al_d  = 21'sd0;
            d6_ar_d  = 21'sd0;
        end else if (d6_in.valid) begin
            d6_cnt_d = d6_cnt_q + 3'h1;
            d6_al_d  = sum_l;
            d6_ar_d  = sum_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            d6_cnt_q <= 3'h0;
            d6_al_q  <= 21'sd0;
            d6_ar_q  <= 21'sd0;
        end else begin
            d6_cnt_q <= d6_cnt_d;
            d6_al_q  <= d6_al_d;
            d6_ar_q  <= d6_ar_d;
        end
    end

    // ************************************************************
    // Output data registers and interrupt pulses
    // ************************************************************
    logic [17:0] left_d, right_d, mono_d, d6l_d, d6r_d;
    logic        irq_st_q, irq_st_d, irq_mo_q, irq_mo_d, irq_d6_q, irq_d6_d;

    always_comb begin
        left_d   = st_valid   ? st_l_data : left_q;
        right_d  = st_r_valid ? st_r_data : right_q;
        mono_d   = mono_valid ? mono_data : mono_q;
        d6l_d    = d6_done ? 18'(sum_l / `ADF_D6_DIV) : d6l_q;
        d6r_d    = d6_done ? 18'(sum_r / `ADF_D6_DIV) : d6r_q;
        irq_st_d = st_valid;
        irq_mo_d = mono_valid;
        irq_d6_d = d6_done;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_q   <= 18'h00000;
            right_q  <= 18'h00000;
            mono_q   <= 18'h00000;
            d6l_q    <= 18'h00000;
            d6r_q    <= 18'h00000;
            irq_st_q <= 1'b0;
            irq_mo_q <= 1'b0;
            irq_d6_q <= 1'b0;
        end else begin
            left_q   <= left_d;
            right_q  <= right_d;
            mono_q   <= mono_d;
            d6l_q    <= d6l_d;
            d6r_q    <= d6r_d;
            irq_st_q <= irq_st_d;
            irq_mo_q <= irq_mo_d;
            irq_d6_q <= irq_d6_d;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign irq_stereo   = irq_st_q;
    assign irq_mono     = irq_mo_q;
    assign irq_dec6     = irq_d6_q;
    assign fm_demod_rst = demod_rst_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_off3;
        !ctrl_q.glb_en [*3];
    endsequence

    a_off_no_irq: assert property (s_off3 |-> !irq_st_q && !irq_mo_q)
        else $error("filter irq while global enable is off");
    a_demod_held: assert property (!ctrl_q.glb_en |-> demod_rst_q)
        else $error("demodulator not held in reset");
    a_restart_quiet: assert property ($rose(ctrl_q.glb_en) |->
        !irq_st_q [*8])
        else $error("stereo sample too soon after restart");
    a_irq_with_data: assert property (irq_st_q |->
        left_q == $past(st_l_data))
        else $error("stereo irq without data update");
    a_irq_one_cycle: assert property (irq_mo_q |=> !irq_mo_q)
        else $error("mono irq longer than one cycle");
    a_stereo_spacing: assert property (irq_st_q |=> !irq_st_q [*8])
        else $error("stereo samples closer than minimum window");
    a_d6_off: assert property (!cfg_q.d6_en [*2] |-> !irq_d6_q)
        else $error("decimation-by-six irq while disabled");
    a_apb_answer: assert property (psel && !penable |=> pready_q ##1
        !pready_q)
        else $error("apb ready not a single access cycle");
    a_div2_toggle: assert property (xclk_div2 |=> !xclk_div2)
        else $error("crystal half clock not toggling");
endmodule

/* logic/adf_defines.svh */
// Purpose: Offsets, field positions, reset values and counts of the filters
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef ADF_DEFINES_SVH
`define ADF_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ADF_OFF_CTRL      8'h00
`define ADF_OFF_CFG       8'h04
`define ADF_OFF_LEFT      8'h08
`define ADF_OFF_LEFT_LSB  8'h0C
`define ADF_OFF_RIGHT     8'h10
`define ADF_OFF_RIGHT_LSB 8'h14
`define ADF_OFF_MONO      8'h18
`define ADF_OFF_MONO_LSB  8'h1C
`define ADF_OFF_D6L       8'h20
`define ADF_OFF_D6L_LSB   8'h24
`define ADF_OFF_D6R       8'h28
`define ADF_OFF_D6R_LSB   8'h2C

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define ADF_CTRL_EXT_R_BIT  14
`define ADF_CTRL_EXT_L_BIT  13
`define ADF_CTRL_EXT_M_BIT  12
`define ADF_CTRL_ENA_BIT    6
`define ADF_CFG_MSB         9
`define ADF_CTRL_RST        4'h0
`define ADF_CFG_RST         10'h000
`define ADF_LSB_POS         14

// ****************************************************************
// Decimation counts (last index of a window), divide-by-six divisor and saturation limits
// ****************************************************************
`define ADF_LAST_32   8'h1F
`define ADF_LAST_64   8'h3F
`define ADF_LAST_128  8'h7F
`define ADF_LAST_256  8'hFF
`define ADF_D6_LAST   3'h5
`define ADF_D6_DIV    21'sh000006
`define ADF_SAT_POS   28'sh001FFFF
`define ADF_SAT_NEG   28'shFFE0000

`endif

/* logic/adf_pkg.sv */
// Purpose: Types shared by the decimation filter block
// Assumes: adf_defines.svh holds all numbers
// Notes:   Field order of adf_cfg_s matches configuration bits 9:0
package adf_pkg;

    typedef struct packed {
        logic       swap;       // Exchange filter two and three inputs
        logic [1:0] d6_sel;     // Decimation-by-six input select
        logic [1:0] mono_rate;  // Mono rate select
        logic [1:0] st_rate;    // Stereo rate select
        logic       d6_en;      // Decimation-by-six enable
        logic       mono_en;    // Mono filter enable
        logic       st_en;      // Stereo filters enable
    } adf_cfg_s;

    typedef struct packed {
        logic ext_r;            // External right input
        logic ext_l;            // External left input
        logic ext_m;            // External mono input
        logic glb_en;           // Global filter enable
    } adf_ctrl_s;

    typedef struct packed {
        logic        valid;
        logic [17:0] left;
        logic [17:0] right;
    } adf_pair_s;

    typedef enum logic [1:0] {
        ADF_D6_FM,
        ADF_D6_STEREO,
        ADF_D6_MONO
    } adf_d6src_e;

endpackage

/* logic/adf_clkdiv.sv */
// Purpose: Crystal clock dividers for filter rate and external converters
// Assumes: clk is the crystal clock
// Notes:   Free running; enables are one-cycle pulses
`timescale 1ns/1ps
module adf_clkdiv (
    input  wire logic clk,        // Crystal clock
    input  wire logic rst_n,      // Async reset, active low
    output logic      en_div2,    // Pulse every second cycle
    output logic      div2_q,     // Crystal / 2 square wave
    output logic      div4_q      // Crystal / 4 square wave
);
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q + 2'h1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 2'h0;
            div2_q <= 1'b0;
            div4_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            div2_q <= cnt_d[0];
            div4_q <= cnt_d[1];
        end
    end

    assign en_div2 = cnt_q[0];
endmodule

/* logic/adf_decim.sv */
// Purpose: One-bit stream decimator with selectable factor, 18-bit result
// Assumes: smp_en pulses at the filter input rate
// Notes:   Accumulate-and-dump, scaled to full range and saturated
`timescale 1ns/1ps
`include "adf_defines.svh"
module adf_decim #(
    parameter int W = 18
) (
    input  wire logic         clk,      // Crystal clock
    input  wire logic         rst_n,    // Async reset, active low
    input  wire logic         clr,      // Hold in reset
    input  wire logic         smp_en,   // Input sample strobe
    input  wire logic         bit_in,   // Modulator bit
    input  wire logic [1:0]   rate,     // Decimation factor select
    output logic [W-1:0]      data_q,   // Output sample
    output logic              valid_q   // New sample pulse
);
    logic [7:0]        cnt_q, cnt_d, last;
    logic signed [9:0] acc_q, acc_d, acc_n;
    logic [W-1:0]      data_d;
    logic              valid_d;
    logic [4:0]        sh;
    logic signed [27:0] scl;

    always_comb begin
        case (rate)
            2'h0:    begin last = `ADF_LAST_32;  sh = 5'd12; end
            2'h1:    begin last = `ADF_LAST_64;  sh = 5'd11; end
            2'h2:    begin last = `ADF_LAST_128; sh = 5'd10; end
            default: begin last = `ADF_LAST_256; sh = 5'd9;  end
        endcase
        acc_n   = bit_in ? acc_q + 10'sd1 : acc_q - 10'sd1;
        scl     = 28'(acc_n) <<< sh;
        cnt_d   = cnt_q;
        acc_d   = acc_q;
        data_d  = data_q;
        valid_d = 1'b0;
        if (clr) begin
            cnt_d = 8'h00;
            acc_d = 10'sd0;
        end else if (smp_en) begin
            if (cnt_q >= last) begin
                cnt_d   = 8'h00;
                acc_d   = 10'sd0;
                valid_d = 1'b1;
                if (scl > `ADF_SAT_POS)
                    data_d = W'(`ADF_SAT_POS);
                else if (scl < `ADF_SAT_NEG)
                    data_d = W'(`ADF_SAT_NEG);
                else
                    data_d = scl[W-1:0];
            end else begin
                cnt_d = cnt_q + 8'h01;
                acc_d = acc_n;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= 8'h00;
            acc_q   <= 10'sd0;
            data_q  <= '0;
            valid_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            acc_q   <= acc_d;
            data_q  <= data_d;
            valid_q <= valid_d;
        end
    end
endmodule

/* testbench/adf_conv_model.sv */
// Purpose: Converter and demodulator stand-in
// Assumes: clk is the crystal clock
// Notes:   Internal bits high, external pins low
`timescale 1ns/1ps
module adf_conv_model
    import adf_pkg::*;
(
    input  wire logic        clk,    // Crystal clock
    input  wire logic        rst_n,  // Async reset, active low
    input  wire logic        div2,   // Crystal / 2 phase
    input  wire logic [17:0] fm_val, // Demodulator value
    output logic      [2:0]  mod_b,  // Internal bits
    output logic      [2:0]  ext_b,  // External pins
    output adf_pair_s        fm_smp  // Demodulator samples
);
    logic [2:0] gap_q;
    logic       hit;
    assign mod_b = 3'h7;
    assign hit = (gap_q == 3'h7);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_b <= 3'h0;
            gap_q <= 3'h0;
            fm_smp <= 37'h0;
        end else begin
            gap_q <= gap_q + 3'h1;
            if (div2) begin
                ext_b <= 3'h0;
            end
            fm_smp.valid <= hit;
            fm_smp.left <= hit ? fm_val : ~fm_val;
            fm_smp.right <= hit ? ~fm_val : fm_val;
        end
    end
endmodule

/* testbench/tb_audio_adc_decimation_filters.sv */
// Purpose: Self-checking bench for the decimation filters
// Assumes: Register map of adf_defines.svh
// Notes:   Reads queue expected words for the monitor
`timescale 1ns/1ps
`include "adf_defines.svh"
module tb_audio_adc_decimation_filters;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, fm_demod_rst, xclk_div2, xclk_div4;
    logic [2:0] irqs, mod_b, ext_b;
    logic [17:0] fm_val = 18'h0, v;
    logic [32:0] exp_q[$];
    adf_pkg::adf_pair_s fm_smp;
    int n_mismatch = 0, n_checks = 0, seed = 57519, n, i, k;
    int ctl[3] = '{32'h2040, 32'h5040, 32'h1040};
    int neg[3] = '{1, 6, 2};
    localparam logic [17:0] P = 18'h1FFFF, N = 18'h20000;
    always #12.5 clk = ~clk;
    adf_top i_dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mod_bit_left(mod_b[0]), .mod_bit_right(mod_b[1]),
        .mod_bit_mono(mod_b[2]), .ext_sample_in_left(ext_b[0]),
        .ext_sample_in_right(ext_b[1]), .ext_sample_in_mono(ext_b[2]),
        .fm_smp(fm_smp), .irq_stereo(irqs[0]), .irq_mono(irqs[1]),
        .irq_dec6(irqs[2]), .fm_demod_rst(fm_demod_rst),
        .xclk_div2(xclk_div2), .xclk_div4(xclk_div4));
    adf_conv_model i_conv (.clk(clk), .rst_n(rst_n), .div2(xclk_div2),
        .fm_val(fm_val), .mod_b(mod_b), .ext_b(ext_b), .fm_smp(fm_smp));
    task chk(input logic [32:0] s, input logic [32:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 9);
        if (pready !== 1'b1) begin
            n_mismatch++;
            complete_run;
        end
        psel <= 0;
        penable <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(0, a, 32'h0);
    endtask
    task rds(input logic [7:0] a, input logic [17:0] x);
        rd(a, {17'h0, x[17:2]});
        rd(a + 8'h04, {17'h0, x[1:0], 14'h0});
    endtask
    task wirq(input int b, output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (irqs[b] !== 1'b1 && c < 2000);
        if (irqs[b] !== 1'b1) begin
            n_mismatch++;
            complete_run;
        end
    endtask
    always @(posedge clk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            chk({pslverr, prdata}, exp_q.pop_front());
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        chk(fm_demod_rst, 1);
        rd(`ADF_OFF_CTRL, 0);
        rd(`ADF_OFF_CFG, 0);
        rd(8'h30, {1'b1, 32'h0});
        #1;
        n = 0;
        k = 0;
        repeat (8) begin
            v[1:0] = {xclk_div4, xclk_div2};
            @(posedge clk);
            #1;
            n += (v[0] != xclk_div2);
            k += (v[1] != xclk_div4);
        end
        chk(n, 8);
        chk(k, 4);
        apb(1, `ADF_OFF_CFG, 32'h7);
        n = 0;
        repeat (300) begin
            @(posedge clk);
            n += (irqs != 3'h0);
        end
        chk(n, 0);
        $display("reset and idle done");
        for (i = 0; i < 4; i++) begin
            apb(1, `ADF_OFF_CFG, (i << 5) | (i << 3) | 3);
            rd(`ADF_OFF_CFG, (i << 5) | (i << 3) | 3);
            apb(1, `ADF_OFF_CTRL, 0);
            apb(1, `ADF_OFF_CTRL, 32'h40);
            wirq(0, n);
            wirq(0, n);
            chk(n, 64 << i);
            chk(irqs[1], 1);
            rds(`ADF_OFF_LEFT, P);
        end
        $display("rates done");
        for (i = 0; i < 3; i++) begin
            apb(1, `ADF_OFF_CFG, 3 | ((i / 2) << 9));
            apb(1, `ADF_OFF_CTRL, 0);
            apb(1, `ADF_OFF_CTRL, ctl[i]);
            wirq(0, n);
            wirq(0, n);
            for (k = 0; k < 3; k++) begin
                v[15:0] = neg[i][k] ? 16'h8000 : 16'h7FFF;
                rd(8'(8'h08 + 8 * k), {17'h0, v[15:0]});
            end
        end
        $display("inputs done");
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            fm_val <= v;
            apb(1, `ADF_OFF_CFG, (i << 7) | 7);
            apb(1, `ADF_OFF_CTRL, 0);
            apb(1, `ADF_OFF_CTRL, i ? 32'h4040 : 32'h40);
            wirq(2, n);
            wirq(2, n);
            if (i == 0) chk(n, 48);
            rds(`ADF_OFF_D6L, i == 0 ? v : P);
            rds(`ADF_OFF_D6R, i == 0 ? ~v : (i == 1 ? N : P));
        end
        chk(fm_demod_rst, 0);
        $display("decimation by six done");
        complete_run;
    end
endmodule
